// ### src/sdbc_pkg.sv
/*
 * Shared types and constants of the switch-dimming buck controller:
 * timing figures with their derived cycle counts, dimming levels,
 * the switching state encoding and the packed state of the top module.
 * Assumes one 50 MHz clock and comparator levels from the analog front.
 */
// What this block does
// - Four brightness levels: 100%, 50%, 25% and 12.5% PWM duty.
// - Line off for 7 ms up to one second and back steps one level along sweep.
// - Fresh sequence starts at 100%; first qualified cycle steps downward.
// - Reaching top or bottom level reverses the sweep direction.
// - Line off over one second restarts at 100% heading downward.
// - Brightness set by about 1 kHz PWM from internal timebase.
// - Line presence sensed on the line-sense pin; a fall is switch-off.
// - Current sense above the 440 mV short comparator enters hiccup.
// - Hiccup stretches the off-time to about 750 us.
// - Current sense ignored during blanking at each switch-on.
// - Regulation-ended on-time never shorter than 760 ns; a short ends it earlier.
// - Constant off-time from resistor setting; on-time ends on regulation.
package sdbc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and timing figures
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CLK_NS = 20;
   localparam int unsigned T_LEB_NS = 110;
   localparam int unsigned T_MIN_ON_NS = 760;
   localparam int unsigned T_HICCUP_US = 750;
   localparam int unsigned F_PWM_HZ = 1000;
   localparam int unsigned T_QUAL_MS = 7;
   localparam int unsigned T_RESET_MS = 1000;

   // Derived cycle counts; least times round up
   localparam int unsigned LEB_CYC = (T_LEB_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned MIN_ON_CYC =
      (T_MIN_ON_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned HICCUP_CYC = T_HICCUP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PWM_CYC = CLK_HZ / F_PWM_HZ;
   localparam int unsigned QUAL_CYC = T_QUAL_MS * (CLK_HZ / 1000);
   localparam int unsigned RESET_CYC = T_RESET_MS * (CLK_HZ / 1000);

   ////////////////////////////////////////////////////////////////////////
   // Dimming levels: index 0 is full, each step halves the duty
   localparam logic [1:0] LVL_FULL = 2'h0;
   localparam logic [1:0] LVL_LOW = 2'h3;
   localparam logic [1:0] LVL_STEP = 2'h1;

   // Off-time setting width in bits; the setting counts clock cycles
   localparam int unsigned OFF_W = 10;

   ////////////////////////////////////////////////////////////////////////
   // Switching states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_BLANK = 4'h2,
      ST_ON = 4'h4,
      ST_OFF = 4'h8
   } sdbc_sw_state_t;

   // Comparator and line-sense levels from the analog front
   typedef struct packed {
      logic line;
      logic cs_reg;
      logic cs_short;
   } sdbc_sense_t;

   // Dimming and protection status toward the pins
   typedef struct packed {
      logic [1:0] level;
      logic dir_down;
      logic pwm;
      logic hiccup;
   } sdbc_status_t;

   // Whole state of the top module
   typedef struct packed {
      sdbc_sense_t s1;
      sdbc_sense_t s2;
      logic line_prev;
      logic [25:0] lost_cnt;
      logic [15:0] pwm_cnt;
      sdbc_sw_state_t sw;
      logic [15:0] sw_cnt;
      logic gate;
      sdbc_status_t st;
   } sdbc_state_t;

   localparam sdbc_state_t STATE_RST = '{
      s1: '0, s2: '0, line_prev: 1'b0, lost_cnt: 26'h0,
      pwm_cnt: 16'h0, sw: ST_IDLE, sw_cnt: 16'h0, gate: 1'b0,
      st: '{level: LVL_FULL, dir_down: 1'b1, pwm: 1'b0, hiccup: 1'b0}
   };

endpackage

// ### src/sdbc_top.sv
/*
 * Digital core of the switch-dimming buck controller: power-cycle
 * dimming sequencer, 1 kHz dimming PWM and constant off-time switching
 * with blanking, minimum on-time and hiccup protection.
 * Assumes asynchronous comparator levels on sense_i and an off-time
 * setting in clock cycles from on-chip logic of the same clock.
 */
module sdbc_top #(
   parameter int unsigned PWM_CYC_P = sdbc_pkg::PWM_CYC,
   parameter int unsigned HICCUP_CYC_P = sdbc_pkg::HICCUP_CYC,
   parameter int unsigned QUAL_CYC_P = sdbc_pkg::QUAL_CYC,
   parameter int unsigned RESET_CYC_P = sdbc_pkg::RESET_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Analog front levels
   input wire sdbc_pkg::sdbc_sense_t sense_i,
   input wire logic [sdbc_pkg::OFF_W-1:0] off_time_resistor_pin_i,
   // Drive and status
   output logic gate_o,
   output sdbc_pkg::sdbc_status_t status_o
);
   import sdbc_pkg::*;

   sdbc_state_t q;
   sdbc_state_t next_q;
   logic run;
   logic line_rise;
   logic [15:0] off_load;
   logic [15:0] glen;
   logic [15:0] hlen;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_q = q;
      // Two-stage synchroniser on comparator levels
      next_q.s1 = sense_i;
      next_q.s2 = q.s1;
      next_q.line_prev = q.s2.line;
      run = q.st.pwm && q.s2.line;
      line_rise = q.s2.line && !q.line_prev;

      // Time the line stays lost, saturating past the reset time
      if (!q.s2.line) begin
         if (32'(q.lost_cnt) <= RESET_CYC_P) begin
            next_q.lost_cnt = q.lost_cnt + 26'h1;
         end
      end else begin
         next_q.lost_cnt = 26'h0;
      end

      // Dimming sequencer on line return
      if (line_rise) begin
         if (32'(q.lost_cnt) > RESET_CYC_P) begin
            next_q.st.level = LVL_FULL;
            next_q.st.dir_down = 1'b1;
         end else if (32'(q.lost_cnt) >= QUAL_CYC_P) begin
            if (q.st.dir_down) begin
               next_q.st.level = q.st.level + LVL_STEP;
               if (q.st.level + LVL_STEP == LVL_LOW) begin
                  next_q.st.dir_down = 1'b0;
               end
            end else begin
               next_q.st.level = q.st.level - LVL_STEP;
               if (q.st.level - LVL_STEP == LVL_FULL) begin
                  next_q.st.dir_down = 1'b1;
               end
            end
         end
      end

      // Dimming PWM: period fixed, high time halves per level
      if (32'(q.pwm_cnt) >= PWM_CYC_P - 1) begin
         next_q.pwm_cnt = 16'h0;
      end else begin
         next_q.pwm_cnt = q.pwm_cnt + 16'h1;
      end
      next_q.st.pwm = 32'(q.pwm_cnt) < (PWM_CYC_P >> q.st.level);

      // Off-time load from the resistor setting, at least one cycle
      if (off_time_resistor_pin_i == '0) begin
         off_load = 16'h0;
      end else begin
         off_load = 16'(off_time_resistor_pin_i - OFF_W'(1));
      end

      // Switching cycle control
      case (q.sw)
         ST_IDLE: begin
            if (run) begin
               next_q.sw = ST_BLANK;
               next_q.sw_cnt = 16'h0;
            end
         end
         ST_BLANK: begin
            next_q.sw_cnt = q.sw_cnt + 16'h1;
            if (!run) begin
               next_q.sw = ST_IDLE;
            end else if (32'(q.sw_cnt) >= LEB_CYC - 1) begin
               next_q.sw = ST_ON;
            end
         end
         ST_ON: begin
            next_q.sw_cnt = q.sw_cnt + 16'h1;
            if (!run) begin
               next_q.sw = ST_IDLE;
            end else if (q.s2.cs_short) begin
               next_q.sw = ST_OFF;
               next_q.st.hiccup = 1'b1;
               next_q.sw_cnt = 16'(HICCUP_CYC_P - 1);
            end else if (q.s2.cs_reg &&
                         32'(q.sw_cnt) >= MIN_ON_CYC - 1) begin
               next_q.sw = ST_OFF;
               next_q.sw_cnt = off_load;
            end
         end
         ST_OFF: begin
            next_q.sw_cnt = q.sw_cnt - 16'h1;
            if (q.sw_cnt == 16'h0) begin
               next_q.st.hiccup = 1'b0;
               next_q.sw_cnt = 16'h0;
               next_q.sw = run ? ST_BLANK : ST_IDLE;
            end
         end
         default: begin
            next_q.sw = ST_IDLE;
            next_q.sw_cnt = 16'h0;
         end
      endcase
      next_q.gate = (next_q.sw == ST_BLANK) || (next_q.sw == ST_ON);
   end

   // State register
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= STATE_RST;
      end else begin
         q <= next_q;
      end
   end

   // Outputs straight from the state register
   assign gate_o = q.gate;
   assign status_o = q.st;

   ////////////////////////////////////////////////////////////////////////
   // Checking helpers: length of gate-high and hiccup runs
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         glen <= 16'h0;
         hlen <= 16'h0;
      end else begin
         // Saturate so a very long pulse cannot wrap to a short count
         if (!q.gate) begin
            glen <= 16'h0;
         end else if (glen != 16'hFFFF) begin
            glen <= glen + 16'h1;
         end
         hlen <= q.st.hiccup ? hlen + 16'h1 : 16'h0;
      end
   end

   // Gate low in the cycle after any cycle with the dimming PWM low
   a_gate_pwm_low: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !status_o.pwm |=> !gate_o)
      else $error("gate high during PWM low phase");

   // Short during blanking has no effect
   a_blank_ignore: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (q.sw == ST_BLANK) |=> !$rose(status_o.hiccup))
      else $error("hiccup entered during blanking");

   // Short after blanking trips hiccup next cycle
   a_short_trip: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (q.sw == ST_ON && q.s2.cs_short && run)
      |=> status_o.hiccup && !gate_o)
      else $error("short did not enter hiccup");

   // Hiccup off-time spans the full hiccup count
   a_hiccup_len: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      $fell(status_o.hiccup) |-> 32'($past(hlen)) == HICCUP_CYC_P - 1)
      else $error("hiccup off-time wrong length");

   // Regulation-ended pulses last at least the minimum on-time
   a_min_on: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      $fell(gate_o) && !status_o.hiccup && $past(run)
      |-> 32'($past(glen)) >= MIN_ON_CYC - 1)
      else $error("on-time below minimum");

   // Long loss restarts at full heading down
   a_long_restart: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      line_rise && 32'(q.lost_cnt) > RESET_CYC_P
      |=> status_o.level == LVL_FULL && status_o.dir_down)
      else $error("long loss did not restart sequence");

   // Short loss from full level steps down one
   a_first_step: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      line_rise && status_o.level == LVL_FULL &&
      32'(q.lost_cnt) >= QUAL_CYC_P && 32'(q.lost_cnt) <= RESET_CYC_P
      |=> status_o.level == LVL_STEP)
      else $error("first power cycle did not step down");

   // Reaching the lowest level turns the sweep upward
   a_sweep_reverse: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      $changed(status_o.level) && status_o.level == LVL_LOW
      |-> !status_o.dir_down)
      else $error("sweep did not reverse at bottom");

   // Full level keeps the PWM high
   a_full_duty: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      status_o.level == LVL_FULL ##1 status_o.level == LVL_FULL
      |-> status_o.pwm)
      else $error("PWM low at full level");

endmodule

// ### verif/sdbc_load_model.sv
/*
 * Power stage and light switch seen from the controller: current sense
 * comparators and the line-sense level.
 * Assumes the gate level is sampled on the same rising clock edge.
 */
module sdbc_load_model
   import sdbc_pkg::*;
#(
   parameter int unsigned RAMP_P = 0
) (
   // Clock
   input wire logic clk_i,
   // Controls
   input wire logic gate_i,
   input wire logic switch_on_i,
   input wire logic short_i,
   // Comparator levels
   output wire sdbc_pkg::sdbc_sense_t sense_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] on_cnt = 16'h0;

   ////////////////////////////////////////////////////////////////////////
   // Inductor ramp while the switch conducts
   always @(posedge clk_i) begin
      on_cnt <= gate_i ? on_cnt + 16'h1 : 16'h0;
   end

   // Comparators trip only while current flows
   assign sense_o.line = switch_on_i;
   assign sense_o.cs_reg = gate_i && (on_cnt >= RAMP_P);
   assign sense_o.cs_short = gate_i && short_i;
endmodule

// ### verif/sdbc_tb_top.sv
/*
 * Bench of the switch-dimming controller: power-cycle table with duty
 * checks, then on/off timing, hiccup, mid-run reset.
 * Assumes the load model and shortened counts.
 */
module sdbc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sdbc_pkg::*;
   localparam int PWM = 64;
   typedef struct {int off; logic [1:0] lvl; logic dn;} sdbc_row_t;
   sdbc_row_t rows [9] = '{'{30, 2'h1, 1'b1}, '{30, 2'h2, 1'b1},
      '{30, 2'h3, 1'b0}, '{30, 2'h2, 1'b0}, '{30, 2'h1, 1'b0},
      '{30, 2'h0, 1'b1}, '{10, 2'h0, 1'b1}, '{30, 2'h1, 1'b1},
      '{250, 2'h0, 1'b1}};
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic sw_on = 1'b1;
   logic short_en = 1'b0;
   logic prev_g = 1'b0;
   logic pwm_d = 1'b0;
   logic hic_seen = 1'b0;
   logic gate_o;
   logic [15:0] run = 16'h0;
   logic [15:0] last_hi = 16'h0;
   logic [15:0] last_lo = 16'h0;
   logic [15:0] hi;
   logic [15:0] hi_exp;
   logic [9:0] off_set = 10'h00A;
   sdbc_sense_t sense;
   sdbc_status_t status_o;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   int bad_pwm = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock, design and load
   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   sdbc_top #(.PWM_CYC_P(PWM), .HICCUP_CYC_P(40), .QUAL_CYC_P(20),
      .RESET_CYC_P(200)) dut (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .sense_i(sense),
      .off_time_resistor_pin_i(off_set), .gate_o(gate_o),
      .status_o(status_o));

   sdbc_load_model #(.RAMP_P(0)) load (.clk_i(clk_sys_i), .gate_i(gate_o),
      .switch_on_i(sw_on), .short_i(short_en), .sense_o(sense));

   ////////////////////////////////////////////////////////////////////////
   // Run lengths of the gate, hiccup and pwm watch, timeout
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (gate_o === prev_g) begin
         run <= run + 16'h1;
      end else begin
         if (prev_g) last_hi <= run;
         else last_lo <= run;
         run <= 16'h1;
      end
      prev_g <= gate_o;
      if (status_o.hiccup === 1'b1) hic_seen <= 1'b1;
      if (gate_o && !status_o.pwm && !pwm_d) bad_pwm <= bad_pwm + 1;
      pwm_d <= status_o.pwm;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Range compare, also for exact values
   task automatic chk(input string nm, input logic [15:0] lo, hi_v, g);
      checked++;
      if ((g < lo) !== 1'b0 || (g > hi_v) !== 1'b0) begin
         fail_count++;
         $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi_v, g);
      end
   endtask

   // Switch off for n cycles, then on and settle
   task automatic power_cycle(input int n);
      sw_on = 1'b0;
      repeat (n) @(negedge clk_sys_i);
      if (n > 4) chk("gate_off", 16'h0, 16'h0, 16'(gate_o));
      sw_on = 1'b1;
      repeat (6) @(negedge clk_sys_i);
   endtask

   // Bounded wait for a gate level, then one edge for the run counters
   task automatic wait_gate(input logic v);
      for (int n = 0; n < 500 && gate_o !== v; n++) @(negedge clk_sys_i);
      chk("gate_wait", 16'(v), 16'(v), 16'(gate_o));
      @(negedge clk_sys_i);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(negedge clk_sys_i);
      chk("rst_gate", 16'h0, 16'h0, 16'(gate_o));
      reset_n_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      chk("rst_level", 16'h0, 16'h0, 16'(status_o.level));
      for (int i = 0; i < 9; i++) begin
         power_cycle(rows[i].off);
         chk("level", rows[i].lvl, rows[i].lvl, 16'(status_o.level));
         chk("dir", rows[i].dn, rows[i].dn, 16'(status_o.dir_down));
         hi = 16'h0;
         repeat (PWM) begin
            @(negedge clk_sys_i);
            hi += 16'(status_o.pwm);
         end
         hi_exp = 16'(PWM >> rows[i].lvl);
         chk("duty", hi_exp, hi_exp, hi);
      end
      wait_gate(1'b0);
      wait_gate(1'b1);
      wait_gate(1'b0);
      chk("on_time", 16'h26, 16'h28, last_hi);
      wait_gate(1'b1);
      chk("off_time", 16'h0A, 16'h0B, last_lo);
      // Zero setting gives the one-cycle least off-time
      off_set = 10'h000;
      wait_gate(1'b0);
      wait_gate(1'b1);
      chk("off_zero", 16'h1, 16'h1, last_lo);
      short_en = 1'b1;
      wait_gate(1'b0);
      wait_gate(1'b1);
      wait_gate(1'b0);
      chk("short_on", 16'h07, 16'h09, last_hi);
      wait_gate(1'b1);
      chk("hiccup_off", 16'h28, 16'h2A, last_lo);
      chk("hiccup_flag", 16'h1, 16'h1, 16'(hic_seen));
      short_en = 1'b0;
      power_cycle(30);
      reset_n_i = 1'b0;
      @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      chk("re_level", 16'h0, 16'h0, 16'(status_o.level));
      chk("re_dir", 16'h1, 16'h1, 16'(status_o.dir_down));
      chk("pwm_gap", 16'h0, 16'h0, 16'(bad_pwm));
      tally_and_finish();
   end
endmodule
